// ==== fault_resp_pkg.sv ====
// shared constants, command codes and types of the fault response block
package fault_resp_pkg;

    // timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int MS_NS            = 1000000;
    localparam int MS_CYCLES        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_DELAY_UNIT_MS = 16;
    localparam int RETRY_UNIT_MS    = 2;
    localparam int RETRY_MIN_MS     = 120;
    localparam int RETRY_MAX_MS     = 83000;
    localparam int TIMER_W          = 18;
    localparam logic [15:0] RETRY_MIN_CODE = 16'(RETRY_MIN_MS / RETRY_UNIT_MS);
    localparam logic [15:0] RETRY_MAX_CODE = 16'(RETRY_MAX_MS / RETRY_UNIT_MS);

    // die temperature thresholds, degrees c
    localparam logic [7:0] DIE_HOT_C  = 8'ha0;
    localparam logic [7:0] DIE_COOL_C = 8'h96;

    // command codes
    localparam logic [7:0] CMD_OPERATION     = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
    localparam logic [7:0] CMD_RESTORE_USER  = 8'h16;
    localparam logic [7:0] CMD_OC_RESP       = 8'h47;
    localparam logic [7:0] CMD_OT_RESP       = 8'h50;
    localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
    localparam logic [7:0] CMD_STATUS_IOUT   = 8'h7b;
    localparam logic [7:0] CMD_STATUS_TEMP   = 8'h7d;
    localparam logic [7:0] CMD_STATUS_CML    = 8'h7e;
    localparam logic [7:0] CMD_STATUS_VENDOR = 8'h80;
    localparam logic [7:0] CMD_DIE_OT_RESP   = 8'hd0;
    localparam logic [7:0] CMD_RESTART_INTVL = 8'hd1;
    localparam logic [7:0] CMD_DEVICE_RESET  = 8'hd2;

    // status bit positions
    localparam int SB_IOUT_OC = 4;
    localparam int SB_TEMP    = 2;
    localparam int SB_CML     = 1;
    localparam int SW_IOUT    = 14;
    localparam int SW_MFR     = 12;
    localparam int SIOUT_OC   = 7;
    localparam int STEMP_OT   = 7;
    localparam int SCML_DATA  = 6;
    localparam int SVEND_OT   = 7;
    localparam int OP_ON_BIT  = 7;

    // response byte fields
    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI   = 2;
    localparam int DLY_LO   = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_01     = 2'h1;
    localparam logic [1:0] RESP_10     = 2'h2;
    localparam logic [1:0] RESP_11     = 2'h3;
    localparam logic [2:0] RETRY_ALWAYS = 3'h7;

    // reset values
    localparam logic [7:0]  OC_RESP_RST  = 8'h00;
    localparam logic [7:0]  OT_RESP_RST  = 8'h00;
    localparam logic [7:0]  DIE_OT_RESP  = 8'hc0;
    localparam logic [15:0] RETRY_RST    = 16'h003c;
    localparam logic        OP_ON_RST    = 1'b1;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [1:0]  len;
        logic [15:0] data;
    } cmd_s;

    typedef enum logic [2:0] {ST_OFF, ST_ON, ST_HOLD, ST_WAIT, ST_RETRY} run_state_e;

endpackage

// ==== ms_tick.sv ====
// millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module ms_tick
#(
    parameter int DIV = 125000
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_q;
    logic          wrap;

    assign wrap = (cnt_q == CW'(DIV - 1));

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
            tick_o <= wrap;
        end
    end
endmodule
`default_nettype wire

// ==== ms_timer.sv ====
// millisecond countdown with start, abort and a done pulse
`timescale 1ns/1ps
`default_nettype none
module ms_timer
#(
    parameter int W = 18
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic         start_i,
    input  wire logic         abort_i,
    input  wire logic [W-1:0] load_i,
    output logic              done_o,
    output logic              busy_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                cnt_q  <= load_i;
                busy_o <= 1'b1;
            end
            else if (abort_i)
                busy_o <= 1'b0;
            else if (busy_o && cnt_q == '0)
            begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
            else if (busy_o && tick_i)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    property p_done_needs_busy;
        @(posedge clk_i) disable iff (rst_i)
        done_o |-> $past(busy_o) && !busy_o;
    endproperty
    a_done_needs_busy: assert property (p_done_needs_busy)
        else $error("timer done without a running count");
endmodule
`default_nettype wire

// ==== fault_response_top.sv ====
// fault response for overcurrent, external and die overtemperature
`timescale 1ns/1ps
`default_nettype none
module fault_response_top
    import fault_resp_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire cmd_s        cmd_i,
    input  wire logic        oc_detect_i,
    input  wire logic        ramping_i,
    input  wire logic        ext_ot_i,
    input  wire logic [7:0]  die_temp_i,
    input  wire logic        run_i,
    input  wire logic [3:0]  alert_mask_i,
    output logic             out_en_o,
    output logic             alert_n_o,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o
);
    run_state_e  st_q;
    run_state_e  st_d;
    logic [7:0]  oc_resp_q;
    logic [7:0]  ot_resp_q;
    logic [15:0] retry_q;
    logic        op_on_q;
    logic        on_q;
    logic        oc_flag_q;
    logic        ot_flag_q;
    logic        die_flag_q;
    logic        cml_flag_q;
    logic        die_shut_q;
    logic        die_shut_d;
    logic        oc_det_q;

    // command decode
    logic        is_byte;
    logic        is_word;
    logic        is_send;
    logic        len_ok;
    logic        cmd_ok;
    logic        wr_ok;
    logic        rd_ok;
    logic        wr_oc;
    logic        wr_ot;
    logic        wr_die;
    logic        wr_retry;
    logic        oc_bad;
    logic        ot_bad;
    logic        retry_bad;
    logic        cml_evt;
    logic [7:0]  code;
    logic [7:0]  dbyte;

    assign code  = cmd_i.code;
    assign dbyte = cmd_i.data[7:0];
    assign is_byte = code == CMD_OPERATION || code == CMD_OC_RESP
                  || code == CMD_OT_RESP || code == CMD_STATUS_BYTE
                  || code == CMD_STATUS_IOUT || code == CMD_STATUS_TEMP
                  || code == CMD_STATUS_CML || code == CMD_STATUS_VENDOR
                  || code == CMD_DIE_OT_RESP;
    assign is_word = code == CMD_STATUS_WORD || code == CMD_RESTART_INTVL;
    assign is_send = code == CMD_CLEAR_FAULTS || code == CMD_RESTORE_USER
                  || code == CMD_DEVICE_RESET;
    // one-byte commands move exactly one byte
    assign len_ok = is_byte ? (cmd_i.len == 2'h1)
                  : is_word ? (cmd_i.len == 2'h2)
                  : (is_send && cmd_i.len == 2'h0 && cmd_i.write);
    assign cmd_ok = cmd_i.valid && len_ok;
    assign wr_ok  = cmd_ok && cmd_i.write;
    assign rd_ok  = cmd_ok && !cmd_i.write;

    assign oc_bad    = dbyte[RESP_HI:RESP_LO] == RESP_01;
    assign ot_bad    = dbyte[RESP_LO];
    assign retry_bad = cmd_i.data < RETRY_MIN_CODE || cmd_i.data > RETRY_MAX_CODE;
    assign wr_oc     = wr_ok && code == CMD_OC_RESP;
    assign wr_ot     = wr_ok && code == CMD_OT_RESP;
    assign wr_die    = wr_ok && code == CMD_DIE_OT_RESP;
    assign wr_retry  = wr_ok && code == CMD_RESTART_INTVL;
    // unsupported codes, wrong byte counts, rejected values and die overtemp response writes flag a comm logic fault
    assign cml_evt = (cmd_i.valid && !len_ok)
                  || (wr_oc && oc_bad)
                  || (wr_ot && ot_bad)
                  || wr_die
                  || (wr_retry && retry_bad);

    // clearing events
    logic on_cmd;
    logic on_rise;
    logic clr_all;
    logic clr_oc;
    logic clr_ot;
    logic clr_die;
    logic clr_cml;

    assign on_cmd  = run_i && op_on_q;
    assign on_rise = on_cmd && !on_q;
    // clear, restore, device reset, off-then-on, or write one
    assign clr_all = (wr_ok && (code == CMD_CLEAR_FAULTS || code == CMD_RESTORE_USER
                  || code == CMD_DEVICE_RESET)) || on_rise;
    assign clr_oc  = clr_all || (wr_ok && code == CMD_STATUS_IOUT && dbyte[SIOUT_OC]);
    assign clr_ot  = clr_all || (wr_ok && code == CMD_STATUS_TEMP && dbyte[STEMP_OT]);
    assign clr_die = clr_all || (wr_ok && code == CMD_STATUS_VENDOR && dbyte[SVEND_OT]);
    assign clr_cml = clr_all || (wr_ok && code == CMD_STATUS_CML && dbyte[SCML_DATA]);

    // fault qualification
    logic       oc_det;
    logic       die_hot;
    logic       die_cool;
    logic [1:0] oc_mode;
    logic [1:0] ot_mode;
    logic       oc_retry;
    logic       ot_retry;
    logic       oc_imm;
    logic       ot_raw;
    logic       ot_nr;
    logic       oc_sd;
    logic       oc_tmr_done;
    logic       ot_sd;
    logic       sd_req;
    logic       retry_ok;
    logic       fault_gone;

    assign oc_det   = oc_detect_i && !ramping_i;
    assign die_hot  = die_temp_i > DIE_HOT_C;
    assign die_cool = die_temp_i < DIE_COOL_C;
    // die shutdown with hysteresis
    assign die_shut_d = die_hot ? 1'b1 : (die_cool ? 1'b0 : die_shut_q);
    assign oc_mode  = oc_resp_q[RESP_HI:RESP_LO];
    assign ot_mode  = ot_resp_q[RESP_HI:RESP_LO];
    assign oc_retry = oc_resp_q[RETRY_HI:RETRY_LO] == RETRY_ALWAYS;
    assign ot_retry = ot_resp_q[RETRY_HI:RETRY_LO] == RETRY_ALWAYS;
    assign oc_imm   = oc_det && oc_mode == RESP_11;
    assign ot_raw   = ext_ot_i && ot_mode == RESP_10;
    assign ot_nr    = ot_raw && !ot_retry;
    assign oc_sd    = st_q == ST_ON && (oc_imm || (oc_tmr_done && oc_det && oc_mode == RESP_10));
    assign ot_sd    = st_q == ST_ON && ot_raw;
    assign sd_req   = oc_sd || ot_sd;
    // a no-retry cause wins over a retrying one
    assign retry_ok = (!oc_sd || oc_retry) && (!ot_sd || ot_retry);
    assign fault_gone = !oc_detect_i && !ext_ot_i;

    // timers
    logic               tick;
    logic               oc_tmr_start;
    logic               oc_tmr_abort;
    logic [TIMER_W-1:0] oc_load;
    logic               rt_start;
    logic               rt_abort;
    logic               rt_done;
    logic [TIMER_W-1:0] rt_load;

    // delay field in 16 ms units, ride through while persistent
    assign oc_load = TIMER_W'(oc_resp_q[DLY_HI:DLY_LO] * OC_DELAY_UNIT_MS);
    assign oc_tmr_start = oc_det && !oc_det_q && oc_mode == RESP_10 && st_q == ST_ON;
    assign oc_tmr_abort = !oc_det || oc_mode != RESP_10 || st_q != ST_ON;
    // retry interval counts only once the fault is gone
    assign rt_load  = TIMER_W'(retry_q * RETRY_UNIT_MS);
    assign rt_start = st_q == ST_WAIT && fault_gone && !ot_nr && on_cmd;
    assign rt_abort = !rt_start && st_q != ST_RETRY;

    ms_tick #(.DIV(MS_DIV)) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    ms_timer #(.W(TIMER_W)) u_oc_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .start_i (oc_tmr_start),
        .abort_i (oc_tmr_abort),
        .load_i  (oc_load),
        .done_o  (oc_tmr_done),
        .busy_o  ()
    );

    ms_timer #(.W(TIMER_W)) u_rt_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .start_i (rt_start),
        .abort_i (rt_abort),
        .load_i  (rt_load),
        .done_o  (rt_done),
        .busy_o  ()
    );

    // output run state
    always_comb
    begin
        st_d = st_q;
        if (!on_cmd)
            st_d = ST_OFF;
        else
            case (st_q)
                ST_OFF:   st_d = ST_ON;
                ST_ON:    if (sd_req) st_d = retry_ok ? ST_WAIT : ST_HOLD;
                ST_HOLD:  if (clr_oc || clr_ot) st_d = ST_ON;
                ST_WAIT:  if (ot_nr) st_d = ST_HOLD;
                          else if (rt_start) st_d = ST_RETRY;
                ST_RETRY: if (ot_nr) st_d = ST_HOLD;
                          else if (!fault_gone) st_d = ST_WAIT;
                          else if (rt_done) st_d = ST_ON;
                default:  st_d = ST_OFF;
            endcase
    end

    // status views
    logic [7:0]  st_byte;
    logic [15:0] st_word;
    logic [7:0]  st_iout;
    logic [7:0]  st_temp;
    logic [7:0]  st_cml;
    logic [7:0]  st_vend;
    logic [7:0]  oc_rd;
    logic [15:0] rd_mux;
    logic [3:0]  flags;

    always_comb
    begin
        st_byte = '0;
        st_byte[SB_IOUT_OC] = oc_flag_q;
        st_byte[SB_TEMP]    = ot_flag_q;
        st_byte[SB_CML]     = cml_flag_q;
        st_word = {8'h00, st_byte};
        st_word[SW_IOUT] = oc_flag_q;
        st_word[SW_MFR]  = die_flag_q;
        st_iout = '0;
        st_iout[SIOUT_OC] = oc_flag_q;
        st_temp = '0;
        st_temp[STEMP_OT] = ot_flag_q;
        st_cml = '0;
        st_cml[SCML_DATA] = cml_flag_q;
        st_vend = '0;
        st_vend[SVEND_OT] = die_flag_q;
    end

    // delay bits hidden for responses 00 and 11
    assign oc_rd = {oc_resp_q[7:3],
                    (oc_mode == RESP_10) ? oc_resp_q[DLY_HI:DLY_LO] : 3'h0};
    assign rd_mux = (code == CMD_OPERATION)     ? {8'h00, op_on_q, 7'h00}
                  : (code == CMD_OC_RESP)       ? {8'h00, oc_rd}
                  : (code == CMD_OT_RESP)       ? {8'h00, ot_resp_q[7:3], 3'h0}
                  : (code == CMD_DIE_OT_RESP)   ? {8'h00, DIE_OT_RESP}
                  : (code == CMD_RESTART_INTVL) ? retry_q
                  : (code == CMD_STATUS_BYTE)   ? {8'h00, st_byte}
                  : (code == CMD_STATUS_WORD)   ? st_word
                  : (code == CMD_STATUS_IOUT)   ? {8'h00, st_iout}
                  : (code == CMD_STATUS_TEMP)   ? {8'h00, st_temp}
                  : (code == CMD_STATUS_CML)    ? {8'h00, st_cml}
                  : (code == CMD_STATUS_VENDOR) ? {8'h00, st_vend}
                  : 16'h0000;
    assign flags = {cml_flag_q, die_flag_q, ot_flag_q, oc_flag_q};

    // settings; rejected writes leave them as they were
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            oc_resp_q <= OC_RESP_RST;
            ot_resp_q <= OT_RESP_RST;
            retry_q   <= RETRY_RST;
            op_on_q   <= OP_ON_RST;
        end
        else
        begin
            if (wr_oc && !oc_bad) oc_resp_q <= dbyte;
            if (wr_ot && !ot_bad) ot_resp_q <= dbyte;
            if (wr_retry && !retry_bad) retry_q <= cmd_i.data;
            if (wr_ok && code == CMD_OPERATION) op_on_q <= dbyte[OP_ON_BIT];
        end
    end

    // sticky flags, a new event wins over a clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            oc_flag_q  <= 1'b0;
            ot_flag_q  <= 1'b0;
            die_flag_q <= 1'b0;
            cml_flag_q <= 1'b0;
        end
        else
        begin
            oc_flag_q  <= oc_det || (oc_flag_q && !clr_oc);
            ot_flag_q  <= ext_ot_i || (ot_flag_q && !clr_ot);
            die_flag_q <= die_hot || (die_flag_q && !clr_die);
            cml_flag_q <= cml_evt || (cml_flag_q && !clr_cml);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q        <= ST_OFF;
            on_q        <= 1'b0;
            oc_det_q    <= 1'b0;
            die_shut_q  <= 1'b0;
            out_en_o    <= 1'b0;
            alert_n_o   <= 1'b1;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= '0;
        end
        else
        begin
            st_q        <= st_d;
            on_q        <= on_cmd;
            oc_det_q    <= oc_det;
            die_shut_q  <= die_shut_d;
            out_en_o    <= st_d == ST_ON && !die_shut_d;
            alert_n_o   <= !(|(flags & ~alert_mask_i));
            rsp_valid_o <= rd_ok;
            rsp_data_o  <= rd_ok ? rd_mux : 16'h0000;
        end
    end

    sequence s_oc_hit;
        st_q == ST_ON && oc_imm && on_cmd;
    endsequence
    sequence s_off_next;
        st_q != ST_ON && !out_en_o;
    endsequence

    property p_oc_flag;
        @(posedge clk_i) disable iff (rst_i) oc_det |=> oc_flag_q && st_iout[SIOUT_OC];
    endproperty
    a_oc_flag: assert property (p_oc_flag)
        else $error("overcurrent flag not set");
    property p_ramp;
        @(posedge clk_i) disable iff (rst_i) ramping_i && !oc_flag_q |=> !oc_flag_q;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("overcurrent taken during ramp");
    property p_ignore;
        @(posedge clk_i) disable iff (rst_i)
        st_q == ST_ON && oc_mode == RESP_IGNORE && !ot_raw && on_cmd |=> st_q == ST_ON;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("output left run under ignore");
    property p_bad_oc;
        @(posedge clk_i) disable iff (rst_i)
        wr_oc && oc_bad |=> cml_flag_q && oc_resp_q == $past(oc_resp_q);
    endproperty
    a_bad_oc: assert property (p_bad_oc)
        else $error("bad overcurrent response accepted");
    property p_oc_imm;
        @(posedge clk_i) disable iff (rst_i) s_oc_hit |=> s_off_next;
    endproperty
    a_oc_imm: assert property (p_oc_imm)
        else $error("no immediate shutdown");
    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        st_q == ST_HOLD && on_cmd && !clr_oc && !clr_ot |=> st_q == ST_HOLD && !out_en_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched output restarted");
    property p_retry;
        @(posedge clk_i) disable iff (rst_i)
        st_q == ST_RETRY && rt_done && fault_gone && on_cmd && !ot_nr |=> st_q == ST_ON;
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry did not restart");
    property p_rd_zero;
        @(posedge clk_i) disable iff (rst_i)
        rd_ok && code == CMD_OC_RESP && oc_mode != RESP_10 |=> rsp_data_o[2:0] == 3'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("delay bits not hidden");
    property p_len;
        @(posedge clk_i) disable iff (rst_i)
        cmd_i.valid && code == CMD_OC_RESP && cmd_i.len != 2'h1 |=> cml_flag_q;
    endproperty
    a_len: assert property (p_len)
        else $error("wrong byte count not flagged");
    property p_die;
        @(posedge clk_i) disable iff (rst_i) die_hot |=> !out_en_o [*2];
    endproperty
    a_die: assert property (p_die)
        else $error("die overtemp did not disable");
endmodule
`default_nettype wire

// ==== host_model.sv ====
// host model issuing commands to the fault response block
`timescale 1ns/1ps
`default_nettype none
module host_model
    import fault_resp_pkg::*;
(
    input  wire logic clk_i,
    output var  cmd_s cmd_o
);
    initial cmd_o = '0;
    // no data, one byte or one word a command
    task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
        cmd_s x;
        x.valid = 1'b1;
        x.write = w;
        x.code = c;
        x.len = (c == CMD_STATUS_WORD || c == CMD_RESTART_INTVL) ? 2'h2 : 2'h1;
        if (c == CMD_CLEAR_FAULTS || c == CMD_RESTORE_USER || c == CMD_DEVICE_RESET)
            x.len = 2'h0;
        x.data = d;
        @(negedge clk_i);
        cmd_o = x;
        @(negedge clk_i);
        cmd_o = '0;
    endtask
endmodule
`default_nettype wire

// ==== fault_response_top_tb.sv ====
// self-checking bench of the fault response block
`timescale 1ns/1ps
`default_nettype none
module fault_response_top_tb
    import fault_resp_pkg::*;
;
    logic        clk, rst, oc, ramp, ext, run, en, alert_n, rv;
    logic [7:0]  temp;
    logic [3:0]  mask;
    logic [15:0] rdat;
    cmd_s        cmd;
    int          bad_count = 0;
    int          compares = 0;
    logic [15:0] expq[$];
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    host_model host_model_inst (.clk_i(clk), .cmd_o(cmd));
    fault_response_top #(.MS_DIV(10)) fault_response_top_inst (
        .clk_i(clk), .rst_i(rst), .cmd_i(cmd), .oc_detect_i(oc), .ramping_i(ramp),
        .ext_ot_i(ext), .die_temp_i(temp), .run_i(run), .alert_mask_i(mask),
        .out_en_o(en), .alert_n_o(alert_n), .rsp_valid_o(rv), .rsp_data_o(rdat));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        expq.push_back(e);
        host_model_inst.issue(1'b0, c, 16'h0000);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host_model_inst.issue(1'b1, c, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // answer watcher
    always @(negedge clk)
        if (rv === 1'b1)
        begin
            if (expq.size() == 0)
                chk("rsp count", 16'h0000, 16'h0001);
            else
                chk("rsp", expq.pop_front(), rdat);
        end
    initial
    begin
        #(8 * 20000);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h40b6));
        {rst, run, oc, ramp, ext, mask} = {2'b11, 7'h0};
        temp = 8'($urandom_range(140, 0));
        cyc(20);
        rst = 1'b0;
        cyc(3);
        chk("en", 16'h1, 16'(en));
        chk("alert_n", 16'h1, 16'(alert_n));
        rd(CMD_OC_RESP, 16'h0000);
        rd(CMD_DIE_OT_RESP, {8'h00, DIE_OT_RESP});
        wr(CMD_DIE_OT_RESP, 16'h0011);
        rd(CMD_DIE_OT_RESP, {8'h00, DIE_OT_RESP});
        wr(CMD_OC_RESP, 16'h00c5);
        rd(CMD_OC_RESP, 16'h00c0);
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        wr(CMD_OC_RESP, 16'h0045);
        rd(CMD_STATUS_CML, 16'h0040);
        rd(CMD_OC_RESP, 16'h00c0);
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        {ramp, oc} = 2'b11;
        cyc(5);
        chk("en", 16'h1, 16'(en));
        ramp = 1'b0;
        cyc(3);
        chk("en", 16'h0, 16'(en));
        chk("alert_n", 16'h0, 16'(alert_n));
        oc = 1'b0;
        cyc(5);
        chk("en", 16'h0, 16'(en));
        rd(CMD_STATUS_IOUT, 16'h0080);
        rd(CMD_STATUS_WORD, 16'h4010);
        wr(CMD_STATUS_IOUT, 16'h0080);
        rd(CMD_STATUS_IOUT, 16'h0000);
        cyc(3);
        chk("en", 16'h1, 16'(en));
        wr(CMD_OC_RESP, 16'h0007);
        rd(CMD_OC_RESP, 16'h0000);
        {mask, oc} = 5'h03;
        cyc(20);
        chk("en", 16'h1, 16'(en));
        chk("alert_n", 16'h1, 16'(alert_n));
        {mask, oc} = 5'h00;
        cyc(3);
        chk("alert_n", 16'h0, 16'(alert_n));
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        wr(CMD_OC_RESP, 16'h0081);
        rd(CMD_OC_RESP, 16'h0081);
        oc = 1'b1;
        cyc(100);
        oc = 1'b0;
        cyc(2);
        oc = 1'b1;
        cyc(140);
        chk("en", 16'h1, 16'(en));
        cyc(40);
        chk("en", 16'h0, 16'(en));
        oc = 1'b0;
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        wr(CMD_OC_RESP, 16'h00f8);
        oc = 1'b1;
        cyc(50);
        chk("en", 16'h0, 16'(en));
        oc = 1'b0;
        cyc(1150);
        chk("en", 16'h0, 16'(en));
        cyc(100);
        chk("en", 16'h1, 16'(en));
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        wr(CMD_OT_RESP, 16'h0080);
        wr(CMD_OT_RESP, 16'h00c0);
        rd(CMD_OT_RESP, 16'h0080);
        ext = 1'b1;
        cyc(3);
        chk("en", 16'h0, 16'(en));
        rd(CMD_STATUS_TEMP, 16'h0080);
        rd(CMD_STATUS_BYTE, 16'h0006);
        ext = 1'b0;
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        temp = DIE_HOT_C + 8'h01;
        cyc(3);
        chk("en", 16'h0, 16'(en));
        rd(CMD_STATUS_VENDOR, 16'h0080);
        rd(CMD_STATUS_WORD, 16'h1000);
        temp = DIE_COOL_C + 8'h05;
        cyc(3);
        chk("en", 16'h0, 16'(en));
        temp = 8'($urandom_range(149, 0));
        cyc(3);
        chk("en", 16'h1, 16'(en));
        rd(CMD_STATUS_VENDOR, 16'h0080);
        wr(CMD_OPERATION, 16'h0000);
        cyc(2);
        chk("en", 16'h0, 16'(en));
        wr(CMD_OPERATION, 16'h0080);
        cyc(3);
        chk("en", 16'h1, 16'(en));
        rd(CMD_OPERATION, 16'h0080);
        rd(CMD_STATUS_VENDOR, 16'h0000);
        wr(CMD_DIE_OT_RESP, 16'h0000);
        rd(CMD_STATUS_CML, 16'h0040);
        wr(CMD_RESTORE_USER, 16'h0000);
        rd(CMD_STATUS_CML, 16'h0000);
        wr(CMD_DIE_OT_RESP, 16'h0000);
        wr(CMD_DEVICE_RESET, 16'h0000);
        rd(CMD_STATUS_CML, 16'h0000);
        cyc(5);
        chk("queue", 16'h0000, 16'(expq.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
